/* File: core/audio_serial_config_regs.sv */
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
// What this block does
// - Bit 11 selects SPI (0) or audio (1); bit 10 enables audio only.
// - Role field 9:8: slave tx, slave rx, master tx, master rx.
// - Bit 7 short or long frame sync, used only in PCM standard.
// - Standard field 5:4: Philips, MSB-justified, LSB-justified, PCM.
// - Bit 3 sets idle level of the serial bit clock.
// - Sample length 2:1: 16, 24, 32 bits; code 11 reserved.
// - Bit 0 slot 16 or 32 bits; slot must cover sample length.
// - Prescaler bit 9 enables the master clock output pin while audio is active (bits 11 and 10 set).
// - Divider equals twice factor 7:0 plus odd bit 8.
// - Prescaler accepts byte, half-word and word writes.
module audio_serial_config_regs
    import audio_cfg_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             audio_active,
    output logic             spi_active,
    output logic [1:0]       audio_role,
    output logic             is_master,
    output logic             is_transmit,
    output logic [1:0]       frame_standard,
    output logic             frame_sync_style,
    output logic             long_sync_active,
    output logic             idle_clock_level,
    output logic [1:0]       sample_length,
    output logic [5:0]       sample_bits,
    output logic             sample_length_bad,
    output logic             slot_length,
    output logic [5:0]       slot_bits,
    output logic             slot_too_short,
    output logic             master_clock_out_enable,
    output logic             odd_divider_bit,
    output logic [7:0]       divider_factor,
    output logic [8:0]       bit_clock_divider,
    output logic             factor_zero
);

    ////////////////////////////////////////////////////////////////////////
    // Bus slave

    logic [31:0] ctrl;
    logic [31:0] psc;
    logic [31:0] ctrl_merged;
    logic [31:0] psc_merged;
    logic        access;
    logic        hit_ctrl;
    logic        hit_psc;

    function automatic logic [5:0] sample_width(input logic [1:0] code);
        case (code)
            2'h0:    sample_width = 6'h10;
            2'h1:    sample_width = 6'h18;
            2'h2:    sample_width = 6'h20;
            default: sample_width = 6'h00;
        endcase
    endfunction : sample_width

    // Zero wait states; unmapped addresses answer with an error
    assign pready   = 1'b1;
    assign access   = psel & penable;
    assign hit_ctrl = (paddr == ctrl_offset);
    assign hit_psc  = (paddr == psc_offset);
    assign pslverr  = access & ~(hit_ctrl | hit_psc);

    audio_byte_merge u_ctrl_merge (
        .old_value (ctrl),
        .wdata     (pwdata),
        .strb      (pstrb),
        .writable  (ctrl_writable_mask),
        .merged    (ctrl_merged)
    );

    audio_byte_merge u_psc_merge (
        .old_value (psc),
        .wdata     (pwdata),
        .strb      (pstrb),
        .writable  (psc_writable_mask),
        .merged    (psc_merged)
    );

    // Reserved bits never leave their reset value
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl <= ctrl_reset;
        end else if (access && pwrite && hit_ctrl) begin
            ctrl <= ctrl_merged;
        end
    end

    // Any mix of byte lanes updates only its own bytes
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            psc <= psc_reset;
        end else if (access && pwrite && hit_psc) begin
            psc <= psc_merged;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            if (paddr == ctrl_offset) begin
                prdata <= ctrl & ctrl_writable_mask;
            end else if (paddr == psc_offset) begin
                prdata <= psc & psc_writable_mask;
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decoded configuration

    logic        mode_audio;
    logic        enable_raw;
    logic [1:0]  std_field;
    logic [1:0]  len_field;

    assign mode_audio   = ctrl[mode_select_bit];
    assign enable_raw   = ctrl[enable_bit];
    assign spi_active   = ~mode_audio;
    assign audio_active = mode_audio & enable_raw;

    assign audio_role  = ctrl[role_lsb +: 2];
    assign is_master   = audio_role[1];
    assign is_transmit = ~audio_role[0];

    assign std_field        = ctrl[standard_lsb +: 2];
    assign frame_standard   = std_field;
    assign frame_sync_style = ctrl[sync_style_bit];
    // Sync style is meaningless outside PCM, so gate it here once
    assign long_sync_active = frame_sync_style & (std_field == std_pcm);

    assign idle_clock_level = ctrl[idle_level_bit];

    assign len_field         = ctrl[sample_len_lsb +: 2];
    assign sample_length     = len_field;
    assign sample_bits       = sample_width(len_field);
    assign sample_length_bad = (len_field == 2'h3);

    assign slot_length    = ctrl[slot_len_bit];
    assign slot_bits      = slot_length ? 6'h20 : 6'h10;
    // Flag only; software is trusted to keep the slot long enough
    assign slot_too_short = sample_length_bad | (sample_width(len_field) > slot_bits);

    // Output pin enable only counts while audio is running
    assign master_clock_out_enable = psc[mclk_out_bit] & audio_active;
    assign odd_divider_bit         = psc[odd_bit];
    assign divider_factor          = psc[factor_lsb +: 8];
    assign bit_clock_divider       = {divider_factor, 1'b0} + {8'h00, odd_divider_bit};
    // Reported, not corrected: a zero factor is a software fault
    assign factor_zero             = (divider_factor == 8'h00);

    ////////////////////////////////////////////////////////////////////////
    // Checks

    // Bus steps that the write and read checks start from
    sequence s_ctrl_write;
        access && pwrite && hit_ctrl;
    endsequence : s_ctrl_write

    sequence s_psc_write;
        access && pwrite && hit_psc;
    endsequence : s_psc_write

    sequence s_read_setup;
        psel && !penable && !pwrite;
    endsequence : s_read_setup

    sequence s_read_ctrl;
        s_read_setup ##0 hit_ctrl;
    endsequence : s_read_ctrl

    sequence s_read_psc;
        s_read_setup ##0 hit_psc;
    endsequence : s_read_psc

    sequence s_read_unmapped;
        s_read_setup ##0 (!hit_ctrl && !hit_psc);
    endsequence : s_read_unmapped

    a_ctrl_write_lands: assert property (@(posedge clk) disable iff (!rstn)
        (s_ctrl_write ##0 (pstrb == 4'hf))
        |=> (ctrl == ($past(pwdata) & ctrl_writable_mask)))
        else $error("control write not stored");

    a_ctrl_hold: assert property (@(posedge clk) disable iff (!rstn)
        !(access && pwrite && hit_ctrl)
        |=> $stable(ctrl))
        else $error("control changed without write");

    a_psc_byte_lane: assert property (@(posedge clk) disable iff (!rstn)
        (s_psc_write ##0 (pstrb == 4'h1))
        |=> (psc[7:0] == $past(pwdata[7:0])) && (psc[9:8] == $past(psc[9:8])))
        else $error("prescaler byte write wrong");

    a_psc_high_lane: assert property (@(posedge clk) disable iff (!rstn)
        (s_psc_write ##0 (pstrb == 4'h2))
        |=> (psc[9:8] == $past(pwdata[9:8])) && (psc[7:0] == $past(psc[7:0])))
        else $error("prescaler upper byte write wrong");

    a_psc_word_write: assert property (@(posedge clk) disable iff (!rstn)
        (s_psc_write ##0 (pstrb == 4'hf))
        |=> (psc == ($past(pwdata) & psc_writable_mask)))
        else $error("prescaler word write wrong");

    a_psc_no_lanes: assert property (@(posedge clk) disable iff (!rstn)
        (s_psc_write ##0 (pstrb == 4'h0))
        |=> $stable(psc))
        else $error("prescaler changed without byte lanes");

    a_psc_hold: assert property (@(posedge clk) disable iff (!rstn)
        !(access && pwrite && hit_psc)
        |=> $stable(psc))
        else $error("prescaler changed without write");

    a_reserved_zero: assert property (@(posedge clk) disable iff (!rstn)
        ((ctrl & ~ctrl_writable_mask) == 32'h0)
        && ((psc & ~psc_writable_mask) == 32'h0))
        else $error("reserved bit set");

    a_read_ctrl: assert property (@(posedge clk) disable iff (!rstn)
        s_read_ctrl
        |=> (prdata == ($past(ctrl) & ctrl_writable_mask)))
        else $error("control read data wrong");

    a_read_psc: assert property (@(posedge clk) disable iff (!rstn)
        s_read_psc
        |=> (prdata == ($past(psc) & psc_writable_mask)))
        else $error("prescaler read data wrong");

    a_read_unmapped: assert property (@(posedge clk) disable iff (!rstn)
        s_read_unmapped
        |=> (prdata == 32'h00000000))
        else $error("unmapped read not zero");

    a_error_unmapped: assert property (@(posedge clk) disable iff (!rstn)
        (access && !hit_ctrl && !hit_psc)
        |-> pslverr)
        else $error("unmapped access without error");

    a_enable_gated: assert property (@(posedge clk) disable iff (!rstn)
        audio_active == (ctrl[11] && ctrl[10]))
        else $error("audio enable not gated by mode");

    a_spi_mode: assert property (@(posedge clk) disable iff (!rstn)
        spi_active == !ctrl[11])
        else $error("spi mode decode wrong");

    a_enable_unused_spi: assert property (@(posedge clk) disable iff (!rstn)
        !ctrl[11]
        |-> !audio_active)
        else $error("audio active in spi mode");

    a_role_decode: assert property (@(posedge clk) disable iff (!rstn)
        (ctrl[9:8] == 2'h2)
        |-> (is_master && is_transmit))
        else $error("role decode wrong");

    a_role_slave_rx: assert property (@(posedge clk) disable iff (!rstn)
        (ctrl[9:8] == 2'h1)
        |-> (!is_master && !is_transmit))
        else $error("slave receive decode wrong");

    a_role_master_rx: assert property (@(posedge clk) disable iff (!rstn)
        (ctrl[9:8] == 2'h3)
        |-> (is_master && !is_transmit))
        else $error("master receive decode wrong");

    a_sync_pcm_only: assert property (@(posedge clk) disable iff (!rstn)
        long_sync_active
        |-> (ctrl[5:4] == 2'h3 && ctrl[7]))
        else $error("long sync outside pcm");

    a_sync_in_pcm: assert property (@(posedge clk) disable iff (!rstn)
        (ctrl[5:4] == 2'h3 && ctrl[7])
        |-> long_sync_active)
        else $error("long sync missing in pcm");

    a_standard_copy: assert property (@(posedge clk) disable iff (!rstn)
        frame_standard == ctrl[5:4])
        else $error("frame standard wrong");

    a_idle_level: assert property (@(posedge clk) disable iff (!rstn)
        (s_ctrl_write ##0 pstrb[0])
        |=> (idle_clock_level == $past(pwdata[3])))
        else $error("idle level not updated");

    a_sample_width: assert property (@(posedge clk) disable iff (!rstn)
        (ctrl[2:1] == 2'h1)
        |-> (sample_bits == 6'h18))
        else $error("sample width wrong");

    a_sample_32: assert property (@(posedge clk) disable iff (!rstn)
        (ctrl[2:1] == 2'h2)
        |-> (sample_bits == 6'h20))
        else $error("long sample width wrong");

    a_sample_reserved: assert property (@(posedge clk) disable iff (!rstn)
        (ctrl[2:1] == 2'h3)
        |-> (sample_length_bad && sample_bits == 6'h00))
        else $error("reserved sample code not flagged");

    a_slot_bits: assert property (@(posedge clk) disable iff (!rstn)
        slot_bits == (ctrl[0] ? 6'h20 : 6'h10))
        else $error("slot width wrong");

    a_slot_short: assert property (@(posedge clk) disable iff (!rstn)
        (ctrl[2:1] == 2'h2 && !ctrl[0])
        |-> slot_too_short)
        else $error("short slot not flagged");

    a_divider_value: assert property (@(posedge clk) disable iff (!rstn)
        bit_clock_divider == 9'(2 * psc[7:0] + psc[8]))
        else $error("divider value wrong");

    a_mclk_enable: assert property (@(posedge clk) disable iff (!rstn)
        master_clock_out_enable
        |-> (psc[9] && ctrl[11] && ctrl[10]))
        else $error("master clock out without enable");

    a_mclk_on: assert property (@(posedge clk) disable iff (!rstn)
        (psc[9] && ctrl[11] && ctrl[10])
        |-> master_clock_out_enable)
        else $error("master clock out missing");

    a_factor_zero: assert property (@(posedge clk) disable iff (!rstn)
        factor_zero == (psc[7:0] == 8'h00))
        else $error("zero factor flag wrong");

endmodule : audio_serial_config_regs

/* File: core/audio_cfg_pkg.sv */
package audio_cfg_pkg;

    localparam logic [11:0] ctrl_offset        = 12'h01c;
    localparam logic [11:0] psc_offset         = 12'h020;
    localparam logic [31:0] ctrl_reset         = 32'h00000000;
    localparam logic [31:0] psc_reset          = 32'h00000002;
    localparam logic [31:0] ctrl_writable_mask = 32'h00000fbf;
    localparam logic [31:0] psc_writable_mask  = 32'h000003ff;

    localparam int mode_select_bit   = 11;
    localparam int enable_bit        = 10;
    localparam int role_lsb          = 8;
    localparam int sync_style_bit    = 7;
    localparam int standard_lsb      = 4;
    localparam int idle_level_bit    = 3;
    localparam int sample_len_lsb    = 1;
    localparam int slot_len_bit      = 0;
    localparam int mclk_out_bit      = 9;
    localparam int odd_bit           = 8;
    localparam int factor_lsb        = 0;

    typedef enum logic [1:0] {
        role_slave_tx,
        role_slave_rx,
        role_master_tx,
        role_master_rx
    } audio_role_t;

    typedef enum logic [1:0] {
        std_philips,
        std_msb_justified,
        std_lsb_justified,
        std_pcm
    } frame_standard_t;

endpackage : audio_cfg_pkg

/* File: core/audio_byte_merge.sv */
`timescale 1ns/1ps
// Byte-lane merge of a write into a register, limited to writable bits
module audio_byte_merge (
    input  wire logic [31:0] old_value,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  strb,
    input  wire logic [31:0] writable,
    output logic      [31:0] merged
);
    always_comb begin
        merged = old_value;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                merged[i*8 +: 8] = (wdata[i*8 +: 8] & writable[i*8 +: 8]) |
                                   (old_value[i*8 +: 8] & ~writable[i*8 +: 8]);
            end
        end
    end
endmodule : audio_byte_merge

/* File: tb/audio_setting_guard.sv */
`timescale 1ns/1ps
// Host-side watch: flags a setting change or a zero factor while audio runs
module audio_setting_guard (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        audio_active,
    input  wire logic [17:0] settings,
    input  wire logic        factor_zero,
    output logic             violation
);
    logic [17:0] held;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            held      <= '0;
            violation <= 1'b0;
        end else begin
            held <= settings;
            if (audio_active && (settings != held || factor_zero)) begin
                violation <= 1'b1;
            end
        end
    end
endmodule : audio_setting_guard

/* File: tb/audio_serial_config_regs_tb_top.sv */
`timescale 1ns/1ps
module audio_serial_config_regs_tb_top
    import audio_cfg_pkg::*;
;
    logic        clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r;
    logic [3:0]  pstrb = '0;
    logic        pready, pslverr, audio_active, spi_active, is_master, is_transmit, frame_sync_style, e;
    logic        long_sync_active, idle_clock_level, sample_length_bad, slot_length, slot_too_short;
    logic        master_clock_out_enable, odd_divider_bit, factor_zero, violation;
    logic [1:0]  audio_role, frame_standard, sample_length, c;
    logic [5:0]  sample_bits, slot_bits, sb;
    logic [7:0]  divider_factor;
    logic [8:0]  bit_clock_divider;
    int          error_cnt = 0, n_checks = 0;

    audio_serial_config_regs DUT (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .audio_active, .spi_active, .audio_role, .is_master, .is_transmit,
        .frame_standard, .frame_sync_style, .long_sync_active, .idle_clock_level, .sample_length,
        .sample_bits, .sample_length_bad, .slot_length, .slot_bits, .slot_too_short,
        .master_clock_out_enable, .odd_divider_bit, .divider_factor, .bit_clock_divider, .factor_zero);
    audio_setting_guard host (.clk, .rstn, .audio_active, .factor_zero, .violation,
        .settings({audio_role, frame_sync_style, frame_standard, idle_clock_level, sample_length,
                   slot_length, odd_divider_bit, divider_factor}));

    initial begin
        forever #2.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task test_done;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Setup cycle, then access held until pready is sampled high
    task xfer(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
        int i;
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            error_cnt++;
            test_done();
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : xfer

    task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        xfer(a, 1'b1, d, s);
    endtask : wr

    task rd(input logic [11:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0, 4'h0);
        chk(r, exp);
    endtask : rd
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(12'h01c, 32'h00000000);
        rd(12'h020, 32'h00000002);
        chk({spi_active, audio_active, bit_clock_divider, factor_zero}, {2'b10, 9'h004, 1'b0});
        $display("reset test done");
        // Every code of the two-bit fields; bit 6 and 31:12 written high
        for (int k = 0; k < 4; k++) begin
            c  = k[1:0];
            sb = (c == 2'h0) ? 6'h10 : (c == 2'h1) ? 6'h18 : (c == 2'h2) ? 6'h20 : 6'h00;
            wr(12'h01c, {20'hfffff, 2'b10, c, 2'b11, c, c[0], c, c[0]}, 4'hf);
            rd(12'h01c, {20'h0, 2'b10, c, 2'b10, c, c[0], c, c[0]});
            chk({audio_role, is_master, is_transmit, frame_standard, long_sync_active},
                {c, c[1], ~c[0], c, c == 2'h3});
            chk({idle_clock_level, sample_bits, sample_length_bad, slot_bits, slot_too_short},
                {c[0], sb, c == 2'h3, c[0] ? 6'h20 : 6'h10, c[1]});
        end
        $display("field test done");
        wr(12'h01c, 32'h00000400, 4'hf);
        chk({spi_active, audio_active}, 2'b10);
        wr(12'h020, 32'h00000105, 4'h1);
        wr(12'h020, 32'h00000300, 4'h2);
        rd(12'h020, 32'h00000305);
        chk({master_clock_out_enable, odd_divider_bit, divider_factor, bit_clock_divider},
            {2'b01, 8'h05, 9'h00b});
        wr(12'h01c, 32'h00000c00, 4'hf);
        chk({spi_active, audio_active, master_clock_out_enable}, 3'b011);
        wr(12'h01c, 32'h00000800, 4'h2);
        chk({audio_active, master_clock_out_enable}, 2'b00);
        $display("mode test done");
        wr(12'h020, 32'hffffffff, 4'h3);
        rd(12'h020, 32'h000003ff);
        chk({factor_zero, bit_clock_divider}, 10'h1ff);
        wr(12'h020, 32'h00000001, 4'hf);
        wr(12'h020, 32'h000000ff, 4'h0);
        rd(12'h020, 32'h00000001);
        chk({e, bit_clock_divider}, 10'h002);
        wr(12'h020, 32'h00000000, 4'h1);
        chk({factor_zero, bit_clock_divider}, 10'h200);
        $display("prescaler test done");
        xfer(12'h024, 1'b0, 32'h0, 4'h0);
        chk({31'h0, e}, 32'h1);
        chk(r, 32'h0);
        wr(12'h024, 32'hffffffff, 4'hf);
        rd(12'h01c, 32'h00000800);
        chk(violation, 1'b0);
        $display("unmapped test done");
        test_done();
    end
endmodule : audio_serial_config_regs_tb_top
